// ### src/audio_port.sv
// Two clock units and two serializers of a frame-based audio serial port.
// Assumes every pin input and the source clocks are synchronous to clk and
// change much slower than clk, so each level is seen for several cycles.
//
// Function
// - Two clock units, two serializers each rx or tx, shared or separate units.
// - Units run when their enable and global enable are one; serializers also need their unit running.
// - A clock unit may run alone, driving only the clock and sync pins.
// - Clearing an enable stops only that unit; transmit ends at frame end.
// - A stopped receiver finishes the slot in progress before halting.
// - Receive holding reads yield samples in slot order.
// - Enabled ready flags drive the interrupt line; enables set by writing one.
// - Four DMA triggers; each ready assertion requests exactly one transfer.
// - In slave mode bit clock and frame sync are inputs.
// - In master mode clock and sync pins are outputs from the source clock.
// - Oversampling clock output is source clock over divider plus one.
// - Bit clock equals source clock over serial divider plus one.
// - Slot width code gives 8 to 32 bits; frame is width times slots.
// - Serial divider zero passes the source clock straight through.
// - Frame sync is word select in I2S format, frame start in TDM.
// - Receive ready sets on a new word; reading the holding register clears it.
// - A word arriving unread sets overrun; writing one clears it.
// - One holding register per serializer serves all slots in turn.
// - Transmit ready is set while holding is empty; a write clears it.
// - Underrun sets a flag and sends zero or the slot's previous word.
// - Data change on falling bit clock edge and are sampled on rising.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
module audio_port
   import audio_port_pkg::*;
(
   // System.
   input wire logic clk,
   input wire logic resetn,
   // Register port.
   input wire audio_port_pkg::reg_req_t req,
   output logic [31:0] rdata,
   // Per-unit source clocks, sampled as levels.
   input wire logic [1:0] unit_source_clock,
   // Pins.
   input wire audio_port_pkg::pins_in_t pins_in,
   output audio_port_pkg::pins_out_t pins_out,
   // Interrupt and DMA triggers.
   output logic irq,
   output logic [1:0] rx_dma_trigger,
   output logic [1:0] tx_dma_trigger
);
   import audio_port_pkg::*;

   // Bits per slot for a slot width code.
   function automatic logic [5:0] slot_bits(input logic [1:0] code);
      slot_bits = {code, 3'b000} + 6'd8;
   endfunction : slot_bits

   // Bits per frame: slot bits times slot count.
   function automatic logic [8:0] frame_bits(input logic [CU_WIDTH-1:0] c);
      logic [8:0] w;
      logic [3:0] n;
      w = {3'b000, slot_bits(c[CU_SLOT_WIDTH_CODE +: 2])};
      n = {1'b0, c[CU_SLOT_COUNT +: 3]} + 4'd1;
      frame_bits = 9'(w * {5'b00000, n});
   endfunction : frame_bits

   state_t s_r;
   state_t s_nxt;

   logic [1:0] eff_sck;
   logic [1:0] eff_fs;
   logic [1:0] tx_rdy;
   logic [1:0] rx_rdy;
   logic [1:0] master;

   ////////////////////////////////////////////////////////////////////////////
   // Effective clock and sync per unit: generated in master mode, pins else.

   always_comb begin
      for (int u = 0; u < 2; u++) begin
         master[u] = s_r.cu_ctl[u][CU_MASTER_MODE];
         eff_sck[u] = master[u] ? s_r.cu[u].sck : pins_in.sck_in[u];
         eff_fs[u] = master[u] ? s_r.cu[u].fs : pins_in.fs_in[u];
      end
      for (int m = 0; m < 2; m++) begin
         rx_rdy[m] = s_r.ser[m].run & ~s_r.ser_ctl[m][SC_TRANSMIT]
            & s_r.ser[m].full;
         tx_rdy[m] = s_r.ser[m].run & s_r.ser_ctl[m][SC_TRANSMIT]
            & ~s_r.ser[m].full;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      logic glob;
      logic src;
      logic src_edge;
      logic sck_fall;
      logic [4:0] div;
      logic [5:0] mdiv;
      logic [8:0] fb;
      logic u;
      logic rise;
      logic fall;
      logic start_lvl;
      logic fs_start;
      logic [4:0] last_bit;
      logic [5:0] sb;
      logic [4:0] nb;
      logic [2:0] ns;
      logic [31:0] word;
      logic stop_req;
      logic [3:0] flags;
      glob = 1'b0;
      src = 1'b0;
      src_edge = 1'b0;
      sck_fall = 1'b0;
      div = 5'h00;
      mdiv = 6'h00;
      fb = 9'h000;
      u = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      start_lvl = 1'b0;
      fs_start = 1'b0;
      last_bit = 5'h00;
      sb = 6'h00;
      nb = 5'h00;
      ns = 3'h0;
      word = 32'h00000000;
      stop_req = 1'b0;
      flags = 4'h0;
      s_nxt = s_r;
      s_nxt.rdata = 32'h00000000;
      glob = s_r.main_ctl[MC_ENABLE];

      // Register writes.
      if (req.wr) begin
         case (req.addr)
            OFS_MAIN_CONTROL: s_nxt.main_ctl = req.wdata[MC_WIDTH-1:0];
            OFS_CLOCK_UNIT_CONTROL0: s_nxt.cu_ctl[0] = req.wdata[CU_WIDTH-1:0];
            OFS_CLOCK_UNIT_CONTROL1: s_nxt.cu_ctl[1] = req.wdata[CU_WIDTH-1:0];
            OFS_SERIALIZER_CONTROL0: s_nxt.ser_ctl[0] = req.wdata[SC_WIDTH-1:0];
            OFS_SERIALIZER_CONTROL1: s_nxt.ser_ctl[1] = req.wdata[SC_WIDTH-1:0];
            OFS_INTERRUPT_ENABLE_CLR: s_nxt.ien = s_r.ien & ~req.wdata[3:0];
            OFS_INTERRUPT_ENABLE_SET: s_nxt.ien = s_r.ien | req.wdata[3:0];
            OFS_INTERRUPT_FLAGS: begin
               for (int m = 0; m < 2; m++) begin
                  if (req.wdata[IF_RX_OVERRUN + m])
                     s_nxt.ser[m].ovr = 1'b0;
                  if (req.wdata[IF_TX_UNDERRUN + m])
                     s_nxt.ser[m].unr = 1'b0;
               end
            end
            OFS_SAMPLE_HOLDING0, OFS_SAMPLE_HOLDING1: begin
               u = req.addr[2];
               if (s_r.ser_ctl[u][SC_TRANSMIT] && s_r.ser[u].run) begin
                  s_nxt.ser[u].hold = req.wdata;
                  s_nxt.ser[u].full = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // Register reads; the answer stands one cycle later.
      if (req.rd) begin
         for (int m = 0; m < 2; m++) begin
            flags[m] = rx_rdy[m];
            flags[2 + m] = tx_rdy[m];
         end
         case (req.addr)
            OFS_MAIN_CONTROL: s_nxt.rdata = 32'(s_r.main_ctl);
            OFS_CLOCK_UNIT_CONTROL0: s_nxt.rdata = 32'(s_r.cu_ctl[0]);
            OFS_CLOCK_UNIT_CONTROL1: s_nxt.rdata = 32'(s_r.cu_ctl[1]);
            OFS_SERIALIZER_CONTROL0: s_nxt.rdata = 32'(s_r.ser_ctl[0]);
            OFS_SERIALIZER_CONTROL1: s_nxt.rdata = 32'(s_r.ser_ctl[1]);
            OFS_INTERRUPT_ENABLE_CLR,
            OFS_INTERRUPT_ENABLE_SET: s_nxt.rdata = 32'(s_r.ien);
            OFS_INTERRUPT_FLAGS: s_nxt.rdata = 32'({s_r.ser[1].unr,
               s_r.ser[0].unr, s_r.ser[1].ovr, s_r.ser[0].ovr, flags});
            OFS_SAMPLE_HOLDING0, OFS_SAMPLE_HOLDING1: begin
               u = req.addr[2];
               s_nxt.rdata = s_r.ser[u].hold;
               if (!s_r.ser_ctl[u][SC_TRANSMIT])
                  s_nxt.ser[u].full = 1'b0;
            end
            default: s_nxt.rdata = 32'h00000000;
         endcase
      end

      // Clock units.
      for (int c = 0; c < 2; c++) begin
         src = s_r.cu_ctl[c][CU_MCK_SRC_SEL] | s_r.cu_ctl[c][CU_SCK_SRC_SEL]
            ? pins_in.mck_in[c] : unit_source_clock[c];
         src_edge = src != s_r.cu[c].src_prev;
         s_nxt.cu[c].src_prev = src;
         div = s_r.cu_ctl[c][CU_SERIAL_CLK_DIV +: 5];
         mdiv = s_r.cu_ctl[c][CU_MCK_OUT_DIV +: 6];
         fb = frame_bits(s_r.cu_ctl[c]);
         sck_fall = 1'b0;
         // Stopping at a frame boundary keeps a partial frame off the pins.
         if (glob && s_r.main_ctl[MC_CLOCK_UNIT_ENABLE + c])
            s_nxt.cu[c].run = 1'b1;
         else if (!s_r.cu[c].run || s_r.cu[c].bidx == 9'h000
               || !master[c])
            s_nxt.cu[c].run = 1'b0;
         if (s_r.cu[c].run && master[c] && src_edge) begin
            // Counting both source edges gives an exact divide by div+1.
            if (s_r.cu[c].hcnt >= div) begin
               s_nxt.cu[c].hcnt = 5'h00;
               s_nxt.cu[c].sck = ~s_r.cu[c].sck;
               sck_fall = s_r.cu[c].sck;
            end else begin
               s_nxt.cu[c].hcnt = s_r.cu[c].hcnt + 5'd1;
            end
            if (s_r.cu[c].mhcnt >= mdiv) begin
               s_nxt.cu[c].mhcnt = 6'h00;
               s_nxt.cu[c].mck = ~s_r.cu[c].mck;
            end else begin
               s_nxt.cu[c].mhcnt = s_r.cu[c].mhcnt + 6'd1;
            end
         end
         if (sck_fall) begin
            s_nxt.cu[c].bidx = (s_r.cu[c].bidx + 9'd1 >= fb) ? 9'h000
               : s_r.cu[c].bidx + 9'd1;
            // Word select low for the left half; TDM pulses on bit zero.
            if (s_r.cu_ctl[c][CU_TDM_FORMAT])
               s_nxt.cu[c].fs = s_nxt.cu[c].bidx == 9'h000;
            else
               s_nxt.cu[c].fs = s_nxt.cu[c].bidx >= {1'b0, fb[8:1]};
         end
         if (!s_r.cu[c].run) begin
            s_nxt.cu[c].hcnt = 5'h00;
            s_nxt.cu[c].mhcnt = 6'h00;
            s_nxt.cu[c].sck = 1'b0;
            s_nxt.cu[c].mck = 1'b0;
            // Parked on the last bit, so the first fall opens a whole frame.
            s_nxt.cu[c].bidx = fb - 9'd1;
            s_nxt.cu[c].fs = ~s_r.cu_ctl[c][CU_TDM_FORMAT];
         end
      end

      // Serializers.
      for (int m = 0; m < 2; m++) begin
         u = s_r.ser_ctl[m][SC_CLOCK_UNIT_SEL];
         rise = eff_sck[u] & ~s_r.ser[m].sck_prev;
         fall = ~eff_sck[u] & s_r.ser[m].sck_prev;
         s_nxt.ser[m].sck_prev = eff_sck[u];
         start_lvl = s_r.cu_ctl[u][CU_TDM_FORMAT];
         sb = slot_bits(s_r.cu_ctl[u][CU_SLOT_WIDTH_CODE +: 2]);
         last_bit = sb[4:0] - 5'd1;
         stop_req = !(glob && s_r.main_ctl[MC_SERIALIZER_ENABLE + m]);
         if (!stop_req && s_r.cu[u].run)
            s_nxt.ser[m].run = 1'b1;
         // Position the next rising edge will take.
         if (s_r.ser[m].pend) begin
            nb = 5'h00;
            ns = 3'h0;
         end else if (s_r.ser[m].bitcnt == last_bit) begin
            nb = 5'h00;
            ns = (s_r.ser[m].slot == s_r.cu_ctl[u][CU_SLOT_COUNT +: 3])
               ? 3'h0 : s_r.ser[m].slot + 3'd1;
         end else begin
            nb = s_r.ser[m].bitcnt + 5'd1;
            ns = s_r.ser[m].slot;
         end
         if (s_r.ser[m].run && rise) begin
            s_nxt.ser[m].fs_prev = eff_fs[u];
            // The frame starts one bit after the sync transition.
            fs_start = eff_fs[u] == start_lvl
               && s_r.ser[m].fs_prev != start_lvl;
            s_nxt.ser[m].pend = fs_start;
            if (fs_start)
               s_nxt.ser[m].synced = 1'b1;
            // The sync rise still carries the last bit of the frame.
            if (!s_r.ser[m].pend) begin
               s_nxt.ser[m].bitcnt = nb;
               s_nxt.ser[m].slot = ns;
            end
            if (s_r.ser[m].pend) begin
               s_nxt.ser[m].bitcnt = 5'h00;
               s_nxt.ser[m].slot = 3'h0;
            end
            // Receive: sample on the rising edge, MSB first.
            if (!s_r.ser_ctl[m][SC_TRANSMIT] && s_r.ser[m].synced) begin
               word = {s_r.ser[m].shreg[30:0], pins_in.sd_in[m]};
               s_nxt.ser[m].shreg = word;
               if (s_nxt.ser[m].bitcnt == last_bit) begin
                  s_nxt.ser[m].hold = word << (5'd31 - last_bit);
                  s_nxt.ser[m].full = 1'b1;
                  if (s_r.ser[m].full && !(req.rd && req.addr[2] == m[0]
                        && (req.addr == OFS_SAMPLE_HOLDING0
                        || req.addr == OFS_SAMPLE_HOLDING1)))
                     s_nxt.ser[m].ovr = 1'b1;
                  if (stop_req)
                     s_nxt.ser[m].run = 1'b0;
               end
            end
         end
         // Transmit: change data on the falling edge.
         if (s_r.ser[m].run && fall && s_r.ser_ctl[m][SC_TRANSMIT]
               && s_r.ser[m].synced) begin
            if (nb == 5'h00) begin
               if (ns == 3'h0 && stop_req) begin
                  s_nxt.ser[m].run = 1'b0;
                  word = 32'h00000000;
               end else if (s_r.ser[m].full) begin
                  word = s_r.ser[m].hold;
                  s_nxt.ser[m].full = 1'b0;
               end else begin
                  s_nxt.ser[m].unr = 1'b1;
                  word = s_r.ser_ctl[m][SC_REPEAT_ON_UNDERRUN]
                     ? s_r.ser[m].last[ns] : 32'h00000000;
               end
               s_nxt.ser[m].last[ns] = word;
               s_nxt.ser[m].txw = word;
               s_nxt.ser[m].sd = word[31];
            end else begin
               s_nxt.ser[m].sd = s_r.ser[m].txw[5'd31 - nb];
            end
         end
         // A serializer not yet synchronised stops at once.
         if (stop_req && !s_r.ser[m].synced)
            s_nxt.ser[m].run = 1'b0;
         if (!s_nxt.ser[m].run) begin
            s_nxt.ser[m].synced = 1'b0;
            s_nxt.ser[m].pend = 1'b0;
            s_nxt.ser[m].full = 1'b0;
            s_nxt.ser[m].sd = 1'b0;
            s_nxt.ser[m].bitcnt = 5'h00;
            s_nxt.ser[m].slot = 3'h0;
            s_nxt.ser[m].fs_prev = start_lvl;
         end
      end
      s_nxt.rdy_prev = {tx_rdy, rx_rdy};
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.main_ctl <= MC_RESET;
         s_r.cu_ctl <= {CU_RESET, CU_RESET};
         s_r.ser_ctl <= {SC_RESET, SC_RESET};
         s_r.ien <= IEN_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   always_comb begin
      rdata = s_r.rdata;
      irq = |({tx_rdy, rx_rdy} & s_r.ien);
      // One pulse per rising ready flag gives one DMA transfer each.
      rx_dma_trigger = rx_rdy & ~s_r.rdy_prev[1:0];
      tx_dma_trigger = tx_rdy & ~s_r.rdy_prev[3:2];
      for (int c = 0; c < 2; c++) begin
         pins_out.mck_out[c] = s_r.cu[c].mck;
         pins_out.sck_out[c] = s_r.cu[c].sck;
         pins_out.fs_out[c] = s_r.cu[c].fs;
         pins_out.sck_oe[c] = master[c] & s_r.cu[c].run;
         pins_out.fs_oe[c] = master[c] & s_r.cu[c].run;
         pins_out.mck_oe[c] = master[c] & s_r.cu[c].run
            & s_r.cu_ctl[c][CU_MCK_OUT_EN];
      end
      for (int m = 0; m < 2; m++) begin
         pins_out.sd_out[m] = s_r.ser[m].sd;
         pins_out.sd_oe[m] = s_r.ser[m].run & s_r.ser_ctl[m][SC_TRANSMIT];
      end
   end

endmodule : audio_port

// ### src/audio_port_pkg.sv
// Constants, register layout and state types of the two-unit audio port.
// Assumes a single 100 MHz system clock and a register port with reads
// answered one cycle after the strobe.
package audio_port_pkg;

   // Register offsets (byte addresses).
   localparam logic [7:0] OFS_MAIN_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CLOCK_UNIT_CONTROL0 = 8'h04;
   localparam logic [7:0] OFS_CLOCK_UNIT_CONTROL1 = 8'h08;
   localparam logic [7:0] OFS_SERIALIZER_CONTROL0 = 8'h0C;
   localparam logic [7:0] OFS_SERIALIZER_CONTROL1 = 8'h10;
   localparam logic [7:0] OFS_INTERRUPT_ENABLE_CLR = 8'h14;
   localparam logic [7:0] OFS_INTERRUPT_ENABLE_SET = 8'h18;
   localparam logic [7:0] OFS_INTERRUPT_FLAGS = 8'h1C;
   localparam logic [7:0] OFS_SAMPLE_HOLDING0 = 8'h20;
   localparam logic [7:0] OFS_SAMPLE_HOLDING1 = 8'h24;

   // main_control fields.
   localparam int MC_ENABLE = 0;
   localparam int MC_CLOCK_UNIT_ENABLE = 1;
   localparam int MC_SERIALIZER_ENABLE = 3;
   localparam int MC_WIDTH = 5;

   // clock_unit_control fields.
   localparam int CU_SLOT_WIDTH_CODE = 0;
   localparam int CU_SLOT_COUNT = 2;
   localparam int CU_MASTER_MODE = 5;
   localparam int CU_MCK_OUT_EN = 6;
   localparam int CU_MCK_SRC_SEL = 7;
   localparam int CU_SCK_SRC_SEL = 8;
   localparam int CU_SERIAL_CLK_DIV = 9;
   localparam int CU_MCK_OUT_DIV = 14;
   localparam int CU_TDM_FORMAT = 20;
   localparam int CU_WIDTH = 21;

   // serializer_control fields.
   localparam int SC_TRANSMIT = 0;
   localparam int SC_CLOCK_UNIT_SEL = 1;
   localparam int SC_REPEAT_ON_UNDERRUN = 2;
   localparam int SC_WIDTH = 3;

   // interrupt_flags fields, two bits each (one per serializer).
   localparam int IF_RX_READY = 0;
   localparam int IF_TX_READY = 2;
   localparam int IF_RX_OVERRUN = 4;
   localparam int IF_TX_UNDERRUN = 6;

   // Reset values.
   localparam logic [MC_WIDTH-1:0] MC_RESET = 5'h00;
   localparam logic [CU_WIDTH-1:0] CU_RESET = 21'h000000;
   localparam logic [SC_WIDTH-1:0] SC_RESET = 3'h0;
   localparam logic [3:0] IEN_RESET = 4'h0;

   typedef struct packed {
      logic src_prev;
      logic [4:0] hcnt;
      logic sck;
      logic [5:0] mhcnt;
      logic mck;
      logic [8:0] bidx;
      logic fs;
      logic run;
   } clock_unit_t;

   typedef struct packed {
      logic run;
      logic synced;
      logic pend;
      logic sck_prev;
      logic fs_prev;
      logic [4:0] bitcnt;
      logic [2:0] slot;
      logic [31:0] shreg;
      logic [31:0] txw;
      logic [31:0] hold;
      logic full;
      logic ovr;
      logic unr;
      logic sd;
      logic [7:0][31:0] last;
   } serializer_t;

   typedef struct packed {
      logic [MC_WIDTH-1:0] main_ctl;
      logic [1:0][CU_WIDTH-1:0] cu_ctl;
      logic [1:0][SC_WIDTH-1:0] ser_ctl;
      logic [3:0] ien;
      logic [3:0] rdy_prev;
      logic [31:0] rdata;
      logic [1:0] cu_run_prev;
      clock_unit_t [1:0] cu;
      serializer_t [1:0] ser;
   } state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [1:0] mck_in;
      logic [1:0] sck_in;
      logic [1:0] fs_in;
      logic [1:0] sd_in;
   } pins_in_t;

   typedef struct packed {
      logic [1:0] mck_out;
      logic [1:0] mck_oe;
      logic [1:0] sck_out;
      logic [1:0] sck_oe;
      logic [1:0] fs_out;
      logic [1:0] fs_oe;
      logic [1:0] sd_out;
      logic [1:0] sd_oe;
   } pins_out_t;

endpackage : audio_port_pkg

// ### testbench/audio_port_asserts.sv
// Concurrent checks on the audio port's register port, pins and requests.
// Assumes it is bound to audio_port; serializer 1 is clocked by unit 0.
`timescale 1ns/1ps
module audio_port_asserts
   import audio_port_pkg::*;
(
   // System.
   input wire logic clk,
   input wire logic resetn,
   // Register port.
   input wire audio_port_pkg::reg_req_t req,
   input wire logic [31:0] rdata,
   // Pins and requests.
   input wire audio_port_pkg::pins_out_t pins_out,
   input wire logic irq,
   input wire logic [1:0] rx_dma_trigger,
   input wire logic [1:0] tx_dma_trigger
);
   logic [CU_WIDTH-1:0] cu0_r;
   logic ien_seen_r;
   wire logic ien_wr;
   assign ien_wr = req.wr && req.addr == OFS_INTERRUPT_ENABLE_SET;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cu0_r <= CU_RESET;
         ien_seen_r <= 1'b0;
      end else begin
         if (req.wr && req.addr == OFS_CLOCK_UNIT_CONTROL0) begin
            cu0_r <= req.wdata[CU_WIDTH-1:0];
         end
         ien_seen_r <= ien_seen_r | (ien_wr && |req.wdata[3:0]);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_reset_quiet: assert property (disable iff (1'b0)
      !resetn |=> pins_out.sck_oe == 2'b00 && pins_out.fs_oe == 2'b00
      && irq == 1'b0 && rdata == 32'h0) else $error("active after reset");
   a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 32'h0)
      else $error("read data outside its cycle");
   a_dma_pulse: assert property (
      (rx_dma_trigger | tx_dma_trigger) != 2'b00 |=>
      ((rx_dma_trigger & $past(rx_dma_trigger)) |
      (tx_dma_trigger & $past(tx_dma_trigger))) == 2'b00)
      else $error("trigger longer than one cycle");
   a_irq_needs_en: assert property (irq |-> ien_seen_r)
      else $error("interrupt without enable");
   a_sck_master: assert property (
      pins_out.sck_oe[0] |-> cu0_r[CU_MASTER_MODE])
      else $error("bit clock driven in slave mode");
   a_mck_needs_en: assert property (pins_out.mck_oe[0] |->
      cu0_r[CU_MCK_OUT_EN] && pins_out.sck_oe[0])
      else $error("oversampling clock driven without enable");
   a_oe_pair: assert property (pins_out.sck_oe == pins_out.fs_oe)
      else $error("bit clock and frame sync drive differ");
   a_sck_pace: assert property ($changed(pins_out.sck_out[0]) |=>
      $stable(pins_out.sck_out[0]) [*2]) else $error("bit clock too fast");
   a_tx_on_fall: assert property (
      pins_out.sd_oe[1] && $past(pins_out.sd_oe[1])
      && $changed(pins_out.sd_out[1]) |-> $past(pins_out.sck_out[0]) == 1'b0
      && $past(pins_out.sck_out[0], 2) == 1'b1)
      else $error("transmit data moved off a falling edge");
endmodule : audio_port_asserts
bind audio_port audio_port_asserts i_chk (.clk(clk), .resetn(resetn),
   .req(req), .rdata(rdata), .pins_out(pins_out), .irq(irq),
   .rx_dma_trigger(rx_dma_trigger), .tx_dma_trigger(tx_dma_trigger));

// ### testbench/audio_port_tb.sv
// Bench: unit 0 as I2S master, serializer 0 receiving from a codec model,
// serializer 1 transmitting; assumes a source clock of SRC clk cycles.
`timescale 1ns/1ps
module audio_port_tb;
   import audio_port_pkg::*;
   localparam int SRC = 8;
   localparam logic [31:0] CFG = 32'h4065;
   typedef struct {
      string what;
      logic [31:0] exp;
      logic [31:0] mask;
   } note_t;
   logic clk, resetn, irq, codec_sd, rd_d;
   reg_req_t req;
   logic [31:0] rdata, v;
   logic [2:0] src_cnt;
   logic [1:0] usc, rx_trig, tx_trig;
   pins_in_t pins_in;
   pins_out_t pins_out;
   logic [15:0] lw, rw, tx_sh;
   logic [31:0] tw;
   logic tx_seen;
   wire logic [2:0] clks;
   note_t notes[$];
   note_t nt;
   int miscompares, n_checks, n;
   assign usc = {2{src_cnt[2]}};
   assign clks = {pins_out.fs_out[0], pins_out.mck_out[0], pins_out.sck_out[0]};
   assign pins_in = '{2'b00, 2'b00, 2'b00, {1'b0, codec_sd}};
   audio_port i_dut (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
      .unit_source_clock(usc), .pins_in(pins_in), .pins_out(pins_out),
      .irq(irq), .rx_dma_trigger(rx_trig), .tx_dma_trigger(tx_trig));
   codec_model i_codec (.sck(pins_out.sck_out[0]), .fs(pins_out.fs_out[0]),
      .left(lw), .right(rw), .sd(codec_sd));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) src_cnt <= src_cnt + 3'h1;
   // Far-side capture of the transmit line on each rising bit clock.
   always @(posedge pins_out.sck_out[0]) begin
      tx_sh = {tx_sh[14:0], pins_out.sd_out[1]};
      if (tx_sh === tw[31:16]) tx_seen = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string w, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic report_and_stop();
      if (miscompares == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   // A zero mask notes a read whose value only the driver uses.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
      input string w, output logic [31:0] d);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      notes.push_back('{w, e, m});
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic poll(input int b);
      logic [31:0] f;
      int k;
      f = 32'h0;
      k = 0;
      while (f[b] !== 1'b1 && k < 400) begin
         rd(OFS_INTERRUPT_FLAGS, 32'h0, 32'h0, "", f);
         k++;
      end
      chk("ready_wait", 32'h1, {31'h0, f[b]});
   endtask : poll
   task automatic period(input int s, output int c);
      int st, k;
      logic p;
      c = 0;
      st = 0;
      k = 0;
      p = 1'b1;
      while (st < 2 && k < 2000) begin
         @(posedge clk);
         k++;
         if (st == 1) c++;
         if (!p && clks[s] === 1'b1) st++;
         p = clks[s];
      end
   endtask : period
   always @(posedge clk) begin
      if (rd_d) begin
         nt = notes.pop_front();
         if (nt.mask != 32'h0) chk(nt.what, nt.exp & nt.mask, rdata & nt.mask);
      end
      rd_d = req.rd;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      src_cnt = 3'h0;
      req = '0;
      resetn = 1'b0;
      rd_d = 1'b0;
      miscompares = 0;
      n_checks = 0;
      void'($urandom(32'h2578));
      lw = 16'($urandom);
      rw = lw ^ 16'hA5A5;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(OFS_MAIN_CONTROL, 32'h0, '1, "main_control", v);
      rd(OFS_INTERRUPT_FLAGS, 32'h0, 32'hF3, "flags", v);
      rd(8'h3C, 32'h0, '1, "unmapped", v);
      wr(OFS_CLOCK_UNIT_CONTROL0, CFG);
      wr(OFS_SERIALIZER_CONTROL0, 32'h0);
      wr(OFS_SERIALIZER_CONTROL1, 32'h1 << SC_TRANSMIT);
      wr(OFS_INTERRUPT_ENABLE_SET, 32'h1 << IF_RX_READY);
      wr(OFS_MAIN_CONTROL, 32'h1B);
      rd(OFS_CLOCK_UNIT_CONTROL0, CFG, '1, "clock_unit_control0", v);
      for (int i = 0; i < 4; i++) begin
         poll(IF_RX_READY);
         chk("irq", 32'h1, {31'h0, irq});
         rd(OFS_SAMPLE_HOLDING0, {i % 2 ? rw : lw, 16'h0}, '1, "holding0",
            v);
      end
      poll(IF_TX_READY + 1);
      tw = $urandom | 32'h80000000;
      tx_seen = 1'b0;
      wr(OFS_SAMPLE_HOLDING1, tw);
      period(0, n);
      chk("sck_period", SRC, n);
      period(1, n);
      chk("mck_period", SRC * 2, n);
      period(2, n);
      chk("fs_period", SRC * 32, n);
      chk("tx_word", 32'h1, {31'h0, tx_seen});
      chk("sck_oe", 32'h1, {30'h0, pins_out.sck_oe});
      chk("sd_oe", 32'h2, {30'h0, pins_out.sd_oe});
      repeat (300) @(posedge clk);
      rd(OFS_INTERRUPT_FLAGS, 32'h90, 32'h90, "flags", v);
      rd(OFS_SAMPLE_HOLDING0, 32'h0, 32'h0, "", v);
      poll(IF_RX_READY);
      rd(OFS_SAMPLE_HOLDING0, 32'h0, 32'h0, "", v);
      wr(OFS_INTERRUPT_FLAGS, 32'h1 << IF_RX_OVERRUN);
      rd(OFS_INTERRUPT_FLAGS, 32'h0, 32'h10, "flags", v);
      wr(OFS_MAIN_CONTROL, 32'h3);
      repeat (300) @(posedge clk);
      rd(OFS_SAMPLE_HOLDING0, 32'h0, 32'h0, "", v);
      repeat (300) @(posedge clk);
      rd(OFS_INTERRUPT_FLAGS, 32'h0, 32'h1, "flags", v);
      chk("sd_oe", 32'h0, {30'h0, pins_out.sd_oe});
      period(0, n);
      chk("sck_period", SRC, n);
      report_and_stop();
   end
endmodule : audio_port_tb

// ### testbench/codec_model.sv
// Behavioural codec streaming two fixed 16-bit words in I2S format.
// Assumes the port's bit clock and word select drive it.
`timescale 1ns/1ps
module codec_model (
   // Clocks from the port.
   input wire logic sck,
   input wire logic fs,
   // Words for the left and right slots.
   input wire logic [15:0] left,
   input wire logic [15:0] right,
   // Serial data towards the port.
   output logic sd
);
   logic [15:0] sh;
   logic fs_seen;
   initial begin
      sh = 16'h0;
      // Word select idles high, so the first low level opens a left word.
      fs_seen = 1'b1;
      sd = 1'b0;
   end
   // The word loads at the select change and leaves one bit later.
   always @(negedge sck) begin
      sd <= sh[15];
      fs_seen <= fs;
      if (fs !== fs_seen) begin
         sh <= fs ? right : left;
      end else begin
         sh <= {sh[14:0], ~sh[15]};
      end
   end
endmodule : codec_model
